// ---- inc/ros_pkg.sv ----
// constants and types for the register operand selector
package ros_pkg;
    // addressing byte field positions
    localparam int MOD_MSB = 7;
    localparam int MOD_LSB = 6;
    localparam int REG_MSB = 5;
    localparam int REG_LSB = 3;
    localparam int RM_MSB = 2;
    localparam int RM_LSB = 0;

    // mode field value that names a register operand
    localparam logic [1:0] MOD_REGISTER = 2'h3;

    // register file index of each general register, selector order
    localparam logic [2:0] IDX_A = 3'h0;
    localparam logic [2:0] IDX_C = 3'h1;
    localparam logic [2:0] IDX_D = 3'h2;
    localparam logic [2:0] IDX_B = 3'h3;
    localparam logic [2:0] IDX_SP = 3'h4;
    localparam logic [2:0] IDX_BP = 3'h5;
    localparam logic [2:0] IDX_SI = 3'h6;
    localparam logic [2:0] IDX_DI = 3'h7;

    // selector bit that picks the high byte of a byte register
    localparam int BYTE_HIGH_BIT = 2;

    // reset value of the decoded index outputs
    localparam logic [2:0] IDX_RESET = 3'h0;

    // operand width handed to the register file
    typedef enum logic [1:0] {
        ROS_SIZE_BYTE,
        ROS_SIZE_WORD,
        ROS_SIZE_DWORD
    } ros_size_e;
endpackage : ros_pkg

// ---- inc/ros_sel_if.sv ----
// carrier between the top decoder and each selector map
`timescale 1ns/1ps
interface ros_sel_if;
    logic [2:0] sel;
    logic width;
    logic op32;
    logic [2:0] index;
    logic high_byte;
    ros_pkg::ros_size_e size;

    modport map (input sel, input width, input op32, output index, output high_byte, output size);
    modport user (output sel, output width, output op32, input index, input high_byte, input size);
endinterface : ros_sel_if

// ---- core/ros_reg_map.sv ----
// width-dependent map from a three-bit selector to a register
`timescale 1ns/1ps
module ros_reg_map (
    // selector in, register out
    ros_sel_if.map port
);
    // byte decode ignores operand size, word decode follows it
    always_comb begin
        if (!port.width) begin
            // low pair picks the register, top bit picks the high byte
            port.index = {1'b0, port.sel[ros_pkg::BYTE_HIGH_BIT-1:0]};
            port.high_byte = port.sel[ros_pkg::BYTE_HIGH_BIT];
            port.size = ros_pkg::ROS_SIZE_BYTE;
        end else if (port.op32) begin
            port.index = port.sel;
            port.high_byte = 1'b0;
            port.size = ros_pkg::ROS_SIZE_DWORD;
        end else begin
            port.index = port.sel;
            port.high_byte = 1'b0;
            port.size = ros_pkg::ROS_SIZE_WORD;
        end
    end
endmodule : ros_reg_map

// ---- core/ros_top.sv ----
// register operand selector: addressing byte to register file index
`timescale 1ns/1ps
module ros_top (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // addressing byte from the instruction stream
    input wire logic in_valid,
    input wire logic [7:0] in_addr_byte,
    input wire logic in_width,
    input wire logic in_op32,
    // decode results, one cycle after in_valid
    output logic out_valid,
    output logic rm_is_reg,
    output logic ea_needed,
    output logic [2:0] rm_index,
    output logic rm_high_byte,
    output ros_pkg::ros_size_e rm_size,
    output logic [2:0] reg_index,
    output logic reg_high_byte,
    output ros_pkg::ros_size_e reg_size
);
    // field views of the addressing byte
    logic [1:0] mode_field;
    logic [2:0] reg_field;
    logic [2:0] rm_field;

    // one selector map per field, one table behind both
    ros_sel_if rm_sel ();
    ros_sel_if reg_sel ();

    // mode decode of the byte on the input
    logic mode_is_reg;

    // next values of the registered results
    logic next_rm_is_reg;
    logic next_ea_needed;
    logic [2:0] next_rm_index;
    logic next_rm_high_byte;
    ros_pkg::ros_size_e next_rm_size;
    logic [2:0] next_reg_index;
    logic next_reg_high_byte;
    ros_pkg::ros_size_e next_reg_size;

    // split the byte once so the field edges live in one place
    assign mode_field = in_addr_byte[ros_pkg::MOD_MSB:ros_pkg::MOD_LSB];
    assign reg_field = in_addr_byte[ros_pkg::REG_MSB:ros_pkg::REG_LSB];
    assign rm_field = in_addr_byte[ros_pkg::RM_MSB:ros_pkg::RM_LSB];

    // mode field 11 marks the r/m selector as a register
    assign mode_is_reg = (mode_field == ros_pkg::MOD_REGISTER);

    // r/m selector map inputs
    assign rm_sel.sel = rm_field;
    assign rm_sel.width = in_width;
    assign rm_sel.op32 = in_op32;

    // reg field through an identical map so the tables cannot drift apart
    assign reg_sel.sel = reg_field;
    assign reg_sel.width = in_width;
    assign reg_sel.op32 = in_op32;

    // map for the r/m selector
    ros_reg_map u_rm_map (
        .port(rm_sel.map)
    );

    // map for the reg field
    ros_reg_map u_reg_map (
        .port(reg_sel.map)
    );

    // register operand flag; drops when nothing is taken
    always_comb begin
        next_rm_is_reg = 1'b0;
        if (in_valid) begin
            next_rm_is_reg = mode_is_reg;
        end
    end

    // memory path only starts when mode is not 11
    always_comb begin
        next_ea_needed = 1'b0;
        if (in_valid) begin
            next_ea_needed = !mode_is_reg;
        end
    end

    // r/m index; cleared for a memory operand so no stale register leaks
    always_comb begin
        next_rm_index = rm_index;
        if (in_valid && mode_is_reg) begin
            next_rm_index = rm_sel.index;
        end else if (in_valid) begin
            next_rm_index = ros_pkg::IDX_RESET;
        end
    end

    // r/m high byte; only a byte register names one
    always_comb begin
        next_rm_high_byte = rm_high_byte;
        if (in_valid && mode_is_reg) begin
            next_rm_high_byte = rm_sel.high_byte;
        end else if (in_valid) begin
            next_rm_high_byte = 1'b0;
        end
    end

    // r/m size; width still holds for a memory operand
    always_comb begin
        next_rm_size = rm_size;
        if (in_valid) begin
            next_rm_size = rm_sel.size;
        end
    end

    // reg field index; the reg field always names a register
    always_comb begin
        next_reg_index = reg_index;
        if (in_valid) begin
            next_reg_index = reg_sel.index;
        end
    end

    // reg field high byte
    always_comb begin
        next_reg_high_byte = reg_high_byte;
        if (in_valid) begin
            next_reg_high_byte = reg_sel.high_byte;
        end
    end

    // reg field size
    always_comb begin
        next_reg_size = reg_size;
        if (in_valid) begin
            next_reg_size = reg_sel.size;
        end
    end

    // valid strobe follows the input by one cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid;
        end
    end

    // register operand flag stands one cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rm_is_reg <= 1'b0;
        end else begin
            rm_is_reg <= next_rm_is_reg;
        end
    end

    // effective address request stands one cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ea_needed <= 1'b0;
        end else begin
            ea_needed <= next_ea_needed;
        end
    end

    // r/m index holds until the next taken byte
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rm_index <= ros_pkg::IDX_RESET;
        end else begin
            rm_index <= next_rm_index;
        end
    end

    // r/m high byte holds until the next taken byte
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rm_high_byte <= 1'b0;
        end else begin
            rm_high_byte <= next_rm_high_byte;
        end
    end

    // r/m size holds until the next taken byte
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rm_size <= ros_pkg::ROS_SIZE_BYTE;
        end else begin
            rm_size <= next_rm_size;
        end
    end

    // reg field index register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_index <= ros_pkg::IDX_RESET;
        end else begin
            reg_index <= next_reg_index;
        end
    end

    // reg field high byte register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_high_byte <= 1'b0;
        end else begin
            reg_high_byte <= next_reg_high_byte;
        end
    end

    // reg field size register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_size <= ros_pkg::ROS_SIZE_BYTE;
        end else begin
            reg_size <= next_reg_size;
        end
    end
endmodule : ros_top

// ---- sim/ros_top_props.sv ----
// assertions on the register operand selector ports
`timescale 1ns/1ps
module ros_top_props (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // inputs
    input wire logic in_valid,
    input wire logic [7:0] in_addr_byte,
    input wire logic in_width,
    input wire logic in_op32,
    // outputs
    input wire logic out_valid,
    input wire logic rm_is_reg,
    input wire logic ea_needed,
    input wire logic [2:0] rm_index,
    input wire logic rm_high_byte,
    input wire ros_pkg::ros_size_e rm_size,
    input wire logic [2:0] reg_index,
    input wire logic reg_high_byte,
    input wire ros_pkg::ros_size_e reg_size
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // a taken byte whose mode names a register
    wire mreg = in_valid && in_addr_byte[7:6] == ros_pkg::MOD_REGISTER;
    AST_BYTE16: assert property (mreg && !in_width && !in_op32 |=> rm_size == ros_pkg::ROS_SIZE_BYTE
        && rm_index == {1'b0, $past(in_addr_byte[1:0])} && rm_high_byte == $past(in_addr_byte[2])) else $error("byte16");
    AST_WORD16: assert property (mreg && in_width && !in_op32 |=> rm_size == ros_pkg::ROS_SIZE_WORD
        && rm_index == $past(in_addr_byte[2:0]) && !rm_high_byte) else $error("word16");
    AST_DWORD32: assert property (mreg && in_width && in_op32 |=> rm_size == ros_pkg::ROS_SIZE_DWORD
        && rm_index == $past(in_addr_byte[2:0])) else $error("dword32");
    AST_BYTE32: assert property (mreg && !in_width && in_op32 |=> rm_size == ros_pkg::ROS_SIZE_BYTE
        && rm_index == {1'b0, $past(in_addr_byte[1:0])} && rm_high_byte == $past(in_addr_byte[2])) else $error("byte32");
    AST_REG_FIELD: assert property (in_valid |=> reg_size == rm_size && reg_high_byte == (!$past(in_width)
        && $past(in_addr_byte[5])) && reg_index == ($past(in_width) ? $past(in_addr_byte[5:3])
        : {1'b0, $past(in_addr_byte[4:3])})) else $error("reg field");
    AST_MODE: assert property (in_valid |=> out_valid && ea_needed == !rm_is_reg
        && rm_is_reg == ($past(in_addr_byte[7:6]) == 2'h3)) else $error("mode decode");
    AST_MEM: assert property (in_valid && in_addr_byte[7:6] != 2'h3 |=> ea_needed && !rm_is_reg
        && rm_index == 3'h0 && !rm_high_byte) else $error("memory operand");
    AST_IDLE: assert property (!in_valid |=> !out_valid && !rm_is_reg && !ea_needed) else $error("idle");
    AST_HOLD: assert property (!in_valid |=> $stable(rm_index) && $stable(rm_size)
        && $stable(reg_index) && $stable(reg_size)) else $error("hold");
endmodule : ros_top_props

// ---- sim/tb_top.sv ----
// testbench for the register operand selector
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic in_valid = 1'b0;
    logic [7:0] in_addr_byte = 8'h00;
    logic in_width = 1'b0;
    logic in_op32 = 1'b0;
    logic out_valid, rm_is_reg, ea_needed, rm_high_byte, reg_high_byte;
    logic [2:0] rm_index, reg_index;
    ros_pkg::ros_size_e rm_size, reg_size;
    int fail_count = 0;
    int checks = 0;
    always #50 clock = ~clock;
    ros_top i_dut (.clock(clock), .reset_n(reset_n), .in_valid(in_valid), .in_addr_byte(in_addr_byte),
        .in_width(in_width), .in_op32(in_op32), .out_valid(out_valid), .rm_is_reg(rm_is_reg), .ea_needed(ea_needed),
        .rm_index(rm_index), .rm_high_byte(rm_high_byte), .rm_size(rm_size), .reg_index(reg_index),
        .reg_high_byte(reg_high_byte), .reg_size(reg_size));
    task chk(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task summarize();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // in_valid stays up so calls in a row run back to back
    task dec(logic [7:0] b, logic w, logic o);
        ros_pkg::ros_size_e sz;
        sz = !w ? ros_pkg::ROS_SIZE_BYTE : (o ? ros_pkg::ROS_SIZE_DWORD : ros_pkg::ROS_SIZE_WORD);
        in_valid = 1'b1;
        in_addr_byte = b;
        in_width = w;
        in_op32 = o;
        @(negedge clock);
        chk("out_valid", out_valid, 8'h01);
        chk("rm_is_reg", rm_is_reg, 8'(b[7:6] == 2'h3));
        chk("ea_needed", ea_needed, 8'(b[7:6] != 2'h3));
        if (b[7:6] == 2'h3) begin
            chk("rm_index", rm_index, w ? b[2:0] : {1'b0, b[1:0]});
            chk("rm_high_byte", rm_high_byte, 8'(!w && b[2]));
        end else begin
            chk("rm_index mem", rm_index, 8'h00);
            chk("rm_high_byte mem", rm_high_byte, 8'h00);
        end
        chk("rm_size", rm_size, sz);
        chk("reg_index", reg_index, w ? b[5:3] : {1'b0, b[4:3]});
        chk("reg_high_byte", reg_high_byte, 8'(!w && b[5]));
        chk("reg_size", reg_size, sz);
    endtask : dec
    // every selector in every width and size, then idle
    task t_reg();
        for (int i = 0; i < 32; i++) dec({2'h3, ~i[2:0], i[2:0]}, i[3], i[4]);
        in_valid = 1'b0;
        @(negedge clock);
        chk("out_valid idle", out_valid, 8'h00);
        chk("rm_is_reg idle", rm_is_reg, 8'h00);
        chk("ea_needed idle", ea_needed, 8'h00);
        chk("rm_index hold", rm_index, 8'h07);
        $display("test t_reg done");
    endtask : t_reg
    // memory modes must ask for an effective address
    task t_mem();
        for (int m = 0; m < 3; m++) dec({m[1:0], 6'h2c}, 1'b1, m[0]);
        dec({2'h1, 6'h2c}, 1'b0, 1'b1);
        in_valid = 1'b0;
        @(negedge clock);
        $display("test t_mem done");
    endtask : t_mem
    // reset in mid-run clears out_valid, rm_is_reg, both indices and rm_size, then a fresh byte decodes
    task t_reset();
        dec(8'hff, 1'b1, 1'b1);
        reset_n = 1'b0;
        in_valid = 1'b0;
        @(negedge clock);
        chk("out_valid reset", out_valid, 8'h00);
        chk("rm_is_reg reset", rm_is_reg, 8'h00);
        chk("rm_index reset", rm_index, 8'h00);
        chk("rm_size reset", rm_size, 8'(ros_pkg::ROS_SIZE_BYTE));
        chk("reg_index reset", reg_index, 8'h00);
        reset_n = 1'b1;
        @(negedge clock);
        chk("out_valid after reset", out_valid, 8'h00);
        dec(8'hc4, 1'b1, 1'b1);
        $display("test t_reset done");
    endtask : t_reset
    initial begin
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        t_reg();
        t_mem();
        t_reset();
        summarize();
    end
    // watchdog, well beyond the 58 cycles the tests need
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
endmodule : tb_top
bind ros_top ros_top_props i_props (.clock(clock), .reset_n(reset_n), .in_valid(in_valid),
    .in_addr_byte(in_addr_byte), .in_width(in_width), .in_op32(in_op32), .out_valid(out_valid),
    .rm_is_reg(rm_is_reg), .ea_needed(ea_needed), .rm_index(rm_index), .rm_high_byte(rm_high_byte),
    .rm_size(rm_size), .reg_index(reg_index), .reg_high_byte(reg_high_byte), .reg_size(reg_size));
